/* File: design/hrp_defines.svh */
// Purpose: constants of the host read port, both ends
// Assumes: 10 MHz clock, inputs synchronous to it
// Notes:   byte offsets are word aligned inside an 8-bit space
// Contract
// R01 - wait 135ns after rx reads before rx level
// R02 - wait 135ns after tx status before tx level
// R03 - wait 180ns between two drop-counter reads
// R04 - dummy reads sized for 45ns cycle, optional
// R05 - counters snapshotted at start of read
// R06 - address selects register or fifo to read
// R07 - cycle runs while select and strobe both low
// R08 - strobes high between single reads for gap
// R09 - 16-bit mode leaves upper lanes undriven
// R10 - burst up to 8 dwords or 16 words
// R11 - strobes high between bursts for gap
// R12 - direct select reads rx fifo, any address
// R13 - direct reads use A[2:1], ignore A[7:3]
// R14 - direct select timed like an address line
`ifndef HRP_DEFINES_SVH
`define HRP_DEFINES_SVH
`define HRP_CLK_NS        100
`define HRP_OFF_RX_DATA   8'h00
`define HRP_OFF_RX_STS    8'h20
`define HRP_OFF_TX_STS    8'h28
`define HRP_OFF_TEST      8'h30
`define HRP_OFF_RX_LEVEL  8'h34
`define HRP_OFF_TX_LEVEL  8'h38
`define HRP_OFF_RX_DROP   8'h3c
`define HRP_OFF_FREE_RUN  8'h40
`define HRP_TEST_VALUE    32'h8765_4321
`define HRP_FIFO_WAIT_NS  135
`define HRP_DROP_WAIT_NS  180
`define HRP_GAP_NS        13
`define HRP_DATA_NS       40
`define HRP_FIFO_WAIT_CYC ((`HRP_FIFO_WAIT_NS + `HRP_CLK_NS - 1) / `HRP_CLK_NS)
`define HRP_DROP_WAIT_CYC ((`HRP_DROP_WAIT_NS + `HRP_CLK_NS - 1) / `HRP_CLK_NS)
`define HRP_GAP_CYC       ((`HRP_GAP_NS + `HRP_CLK_NS - 1) / `HRP_CLK_NS)
`define HRP_DATA_CYC      (((`HRP_DATA_NS + `HRP_CLK_NS - 1) / `HRP_CLK_NS) + 1)
`define HRP_BURST_DW      8
`define HRP_BURST_W       16
`define HRP_LVL_DELAY     2
`endif

/* File: design/hrp_pkg.sv */
// Purpose: shared types of the host read port
// Assumes: nothing beyond the defines header
// Notes:   host sequencer states are gray along idle-act-gap
package hrp_pkg;
  typedef enum logic [1:0] {
    HRP_IDLE = 2'b00,
    HRP_ACT  = 2'b01,
    HRP_GAP  = 2'b11,
    HRP_WAIT = 2'b10
  } hrp_hst_t;
  typedef enum logic [1:0] {
    HRP_RES_OTHER = 2'b00,
    HRP_RES_RXFIFO = 2'b01,
    HRP_RES_TXSTS = 2'b10,
    HRP_RES_DROP  = 2'b11
  } hrp_res_t;
endpackage : hrp_pkg

/* File: design/hrp_if.sv */
// Purpose: pins between host and device of the read port
// Assumes: one clock; data keeps its last value while both enables are high
// Notes:   data_oe_n low means the device drives that lane pair
`timescale 1ns/10ps
interface hrp_if;
  logic        chip_select_n;
  logic        read_strobe_n;
  logic [7:1]  addr;
  logic        fifo_sel;
  logic [31:0] data;
  logic [1:0]  data_oe_n;
  modport device (
    input  chip_select_n, read_strobe_n, addr, fifo_sel,
    output data, data_oe_n
  );
  modport host (
    output chip_select_n, read_strobe_n, addr, fifo_sel,
    input  data, data_oe_n
  );
endinterface : hrp_if

/* File: design/hrp_device.sv */
// Purpose: device end of the host read port with rx buffering
// Assumes: pin inputs synchronous to clock_i; no write path here
// Notes:   data appears one clock after an access starts and then holds
`timescale 1ns/10ps
`include "hrp_defines.svh"

module hrp_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic                     clock_i,  // clock
  input  wire logic                     rst_i,    // sync reset
  input  wire logic                     in_valid_i, // push request
  output logic                          in_ready_o, // room left
  input  wire logic [W-1:0]             in_data_i,  // push word
  output logic                          out_valid_o, // word present
  input  wire logic                     out_ready_i, // pop
  output logic [W-1:0]                  out_data_o,  // head word
  output logic [$clog2(D+1)-1:0]        count_o      // fill level
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0]           mem_r [D];
  logic [AW-1:0]          wp_r;
  logic [AW-1:0]          rp_r;
  logic [$clog2(D+1)-1:0] cnt_r;
  wire                    push = in_valid_i & in_ready_o;
  wire                    pop  = out_valid_o & out_ready_i;
  wire [AW-1:0]           wp_inc = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
  wire [AW-1:0]           rp_inc = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;

  assign in_ready_o  = (cnt_r != ($clog2(D+1))'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign count_o     = cnt_r;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_inc;
      if (pop)  rp_r <= rp_inc;
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule : hrp_fifo

////////////////////////////////////////////////////////////////////////////////

module hrp_device #(
  parameter int RX_DEPTH = 4,
  parameter int DROP_W   = 16
) (
  input  wire logic        clock_i,     // clock
  input  wire logic        rst_i,       // sync reset, high
  hrp_if.device            bus,         // host pins
  input  wire logic        bus16_i,     // 1: 16-bit data bus
  input  wire logic        rx_valid_i,  // rx data word offered
  output logic             rx_ready_o,  // rx fifo has room
  input  wire logic [31:0] rx_data_i,   // rx data word
  input  wire logic        rxs_valid_i, // rx status word offered
  output logic             rxs_ready_o, // rx status room
  input  wire logic [31:0] rxs_data_i,  // rx status word
  input  wire logic        txs_valid_i, // tx status word offered
  output logic             txs_ready_o, // tx status room
  input  wire logic [31:0] txs_data_i,  // tx status word
  input  wire logic        rx_drop_i    // one-cycle pulse per dropped frame
);
  localparam int CW = $clog2(RX_DEPTH + 1);

  logic              act_q_r;
  logic [7:1]        addr_q_r;
  logic              fsel_q_r;
  logic [31:0]       data_r;
  logic [1:0]        oe_n_r;
  logic [31:0]       free_r;
  logic [31:0]       free_snap_r;
  logic [DROP_W-1:0] drop_r;
  logic [DROP_W-1:0] drop_snap_r;
  logic [31:0]       rxl_d_r [`HRP_LVL_DELAY];
  logic [31:0]       txl_d_r [`HRP_LVL_DELAY];
  logic              rxd_vld;
  logic [31:0]       rxd_head;
  logic [CW-1:0]     rxd_cnt;
  logic              rxs_vld;
  logic [31:0]       rxs_head;
  logic [1:0]        rxs_cnt;
  logic              txs_vld;
  logic [31:0]       txs_head;
  logic [1:0]        txs_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // access decode

  wire        active   = ~bus.chip_select_n & ~bus.read_strobe_n; // R07
  wire        first    = active & ~act_q_r;
  wire        start    = first | (active & ((bus.addr != addr_q_r)
                                  | (bus.fifo_sel != fsel_q_r))); // R10
  wire [7:0]  boff     = {bus.addr, 1'b0};
  wire [7:0]  woff     = {boff[7:2], 2'b00};
  wire        sel_rxd  = bus.fifo_sel | (woff[7:5] == 3'h0); // R12 R13
  wire        sel_rxs  = ~bus.fifo_sel & (woff == `HRP_OFF_RX_STS);
  wire        sel_txs  = ~bus.fifo_sel & (woff == `HRP_OFF_TX_STS);
  wire        sel_drop = ~bus.fifo_sel & (woff == `HRP_OFF_RX_DROP);
  // in 16-bit mode a word is popped only once its upper half is read
  wire        last_half = ~bus16_i | bus.addr[1]; // R09 R13
  wire        pop_rxd  = start & sel_rxd & last_half;
  wire        pop_rxs  = start & sel_rxs & last_half;
  wire        pop_txs  = start & sel_txs & last_half;
  wire        clr_drop = start & sel_drop & last_half;

  // counters come from the snapshot taken when the cycle opened
  wire [31:0] free_v   = first ? free_r : free_snap_r; // R05
  wire [31:0] drop_v   = first ? 32'(drop_r) : 32'(drop_snap_r); // R05
  wire [31:0] word_w   =
      sel_rxd                           ? (rxd_vld ? rxd_head : 32'h0) :
      sel_rxs                           ? (rxs_vld ? rxs_head : 32'h0) :
      sel_txs                           ? (txs_vld ? txs_head : 32'h0) :
      (woff == `HRP_OFF_TEST)           ? `HRP_TEST_VALUE :
      (woff == `HRP_OFF_RX_LEVEL)       ? rxl_d_r[`HRP_LVL_DELAY-1] :
      (woff == `HRP_OFF_TX_LEVEL)       ? txl_d_r[`HRP_LVL_DELAY-1] :
      sel_drop                          ? drop_v :
      (woff == `HRP_OFF_FREE_RUN)       ? free_v : 32'h0; // R06
  wire [31:0] lane_w   = ~bus16_i ? word_w :
                         {16'h0, bus.addr[1] ? word_w[31:16] : word_w[15:0]}; // R09

  assign bus.data      = data_r;
  assign bus.data_oe_n = oe_n_r;

  ////////////////////////////////////////////////////////////////////////////
  // buffers

  hrp_fifo #(.W(32), .D(RX_DEPTH)) u_rxd (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (rx_valid_i),
    .in_ready_o  (rx_ready_o),
    .in_data_i   (rx_data_i),
    .out_valid_o (rxd_vld),
    .out_ready_i (pop_rxd),
    .out_data_o  (rxd_head),
    .count_o     (rxd_cnt)
  );

  hrp_fifo #(.W(32), .D(2)) u_rxs (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (rxs_valid_i),
    .in_ready_o  (rxs_ready_o),
    .in_data_i   (rxs_data_i),
    .out_valid_o (rxs_vld),
    .out_ready_i (pop_rxs),
    .out_data_o  (rxs_head),
    .count_o     (rxs_cnt)
  );

  hrp_fifo #(.W(32), .D(2)) u_txs (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (txs_valid_i),
    .in_ready_o  (txs_ready_o),
    .in_data_i   (txs_data_i),
    .out_valid_o (txs_vld),
    .out_ready_i (pop_txs),
    .out_data_o  (txs_head),
    .count_o     (txs_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin side

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      act_q_r  <= 1'b0;
      addr_q_r <= '0;
      fsel_q_r <= 1'b0;
      data_r   <= 32'h0;
      oe_n_r   <= 2'b11;
    end else begin
      act_q_r  <= active;
      addr_q_r <= bus.addr;
      fsel_q_r <= bus.fifo_sel;
      oe_n_r   <= {~(active & ~bus16_i), ~active}; // R09
      if (start) data_r <= lane_w; // R06
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counters and delayed level words

  // the level words lag the fill counts by two clocks, which is why the host waits
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      free_r      <= 32'h0;
      free_snap_r <= 32'h0;
      drop_r      <= '0;
      drop_snap_r <= '0;
      for (int i = 0; i < `HRP_LVL_DELAY; i++) begin
        rxl_d_r[i] <= 32'h0;
        txl_d_r[i] <= 32'h0;
      end
    end else begin
      free_r <= free_r + 1'b1;
      if (first) begin
        free_snap_r <= free_r; // R05
        drop_snap_r <= drop_r; // R05
      end
      // a drop in the clearing cycle is kept: set wins over clear
      if (clr_drop) drop_r <= DROP_W'(rx_drop_i);
      else if (rx_drop_i & ~(&drop_r)) drop_r <= drop_r + 1'b1;
      rxl_d_r[0] <= {16'(rxd_cnt), 14'h0, rxs_cnt}; // R01
      txl_d_r[0] <= {30'h0, txs_cnt}; // R02
      for (int i = 1; i < `HRP_LVL_DELAY; i++) begin
        rxl_d_r[i] <= rxl_d_r[i-1];
        txl_d_r[i] <= txl_d_r[i-1];
      end
    end
  end
endmodule : hrp_device

/* File: design/hrp_host.sv */
// Purpose: host end that sequences single and burst reads
// Assumes: device answers one clock after each new address
// Notes:   gap and read-after-read waits are timed here, not by dummy reads
`timescale 1ns/10ps
`include "hrp_defines.svh"

module hrp_host (
  input  wire logic        clock_i,    // clock
  input  wire logic        rst_i,      // sync reset, high
  hrp_if.host              bus,        // device pins
  input  wire logic        bus16_i,    // 1: 16-bit data bus
  input  wire logic        req_valid_i, // read request
  output logic             req_ready_o, // request taken
  input  wire logic [7:1]  req_addr_i,  // first address
  input  wire logic        req_fsel_i,  // direct rx fifo select
  input  wire logic [4:0]  req_len_i,   // beats, 0 reads as 1
  output logic             rsp_valid_o, // one-cycle data pulse
  output logic [31:0]      rsp_data_o,  // read word
  output logic             rsp_last_o   // last beat of the request
);
  hrp_pkg::hrp_hst_t st_r;
  hrp_pkg::hrp_res_t last_r;
  logic        cs_n_r;
  logic        rd_n_r;
  logic [7:1]  addr_r;
  logic        fsel_r;
  logic [4:0]  left_r;
  logic [2:0]  cnt_r;
  logic [31:0] dat_r;
  logic        vld_r;
  logic        lst_r;

  wire [7:0] woff      = {req_addr_i[7:2], 2'b00};
  wire [4:0] max_len   = bus16_i ? 5'(`HRP_BURST_W) : 5'(`HRP_BURST_DW);
  wire [4:0] len1      = (req_len_i == 5'h0) ? 5'h1 : req_len_i;
  wire [4:0] len_w     = (len1 > max_len) ? max_len : len1; // R10
  wire       to_rxl    = ~req_fsel_i & (woff == `HRP_OFF_RX_LEVEL);
  wire       to_txl    = ~req_fsel_i & (woff == `HRP_OFF_TX_LEVEL);
  wire       to_drop   = ~req_fsel_i & (woff == `HRP_OFF_RX_DROP);
  // cycles still owed since the last read of a side-effect resource
  wire [2:0] wait_w    =
      (to_rxl & (last_r == hrp_pkg::HRP_RES_RXFIFO)) ? 3'(`HRP_FIFO_WAIT_CYC) : // R01
      (to_txl & (last_r == hrp_pkg::HRP_RES_TXSTS))  ? 3'(`HRP_FIFO_WAIT_CYC) : // R02
      (to_drop & (last_r == hrp_pkg::HRP_RES_DROP))  ? 3'(`HRP_DROP_WAIT_CYC) : // R03
      3'h0;
  wire       take      = req_valid_i & (st_r == hrp_pkg::HRP_IDLE);
  wire       req_fifo  = req_fsel_i | (woff[7:5] == 3'h0) |
                         (woff == `HRP_OFF_RX_STS);
  wire hrp_pkg::hrp_res_t res_w =
      req_fifo                      ? hrp_pkg::HRP_RES_RXFIFO :
      (woff == `HRP_OFF_TX_STS)     ? hrp_pkg::HRP_RES_TXSTS :
      to_drop                       ? hrp_pkg::HRP_RES_DROP : hrp_pkg::HRP_RES_OTHER;
  wire       beat_done = (st_r == hrp_pkg::HRP_ACT) & (cnt_r == 3'(`HRP_DATA_CYC - 1));

  assign req_ready_o       = take;
  assign bus.chip_select_n = cs_n_r;
  assign bus.read_strobe_n = rd_n_r;
  assign bus.addr          = addr_r;
  assign bus.fifo_sel      = fsel_r;
  assign rsp_valid_o       = vld_r;
  assign rsp_data_o        = dat_r;
  assign rsp_last_o        = lst_r;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_r   <= hrp_pkg::HRP_IDLE;
      last_r <= hrp_pkg::HRP_RES_OTHER;
      cs_n_r <= 1'b1;
      rd_n_r <= 1'b1;
      addr_r <= '0;
      fsel_r <= 1'b0;
      left_r <= '0;
      cnt_r  <= '0;
      dat_r  <= 32'h0;
      vld_r  <= 1'b0;
      lst_r  <= 1'b0;
    end else begin
      vld_r <= 1'b0;
      lst_r <= 1'b0;
      case (st_r)
        hrp_pkg::HRP_IDLE: begin
          if (take) begin
            addr_r <= req_addr_i;
            fsel_r <= req_fsel_i; // R14
            left_r <= len_w;
            last_r <= res_w;
            cnt_r  <= wait_w;
            st_r   <= (wait_w != 3'h0) ? hrp_pkg::HRP_WAIT : hrp_pkg::HRP_ACT;
            cs_n_r <= (wait_w != 3'h0); // R07
            rd_n_r <= (wait_w != 3'h0);
          end
        end
        hrp_pkg::HRP_WAIT: begin
          // address and select already stand; strobes follow later
          cnt_r <= cnt_r - 1'b1; // R04
          if (cnt_r == 3'h1) begin
            cnt_r  <= 3'h0;
            cs_n_r <= 1'b0;
            rd_n_r <= 1'b0;
            st_r   <= hrp_pkg::HRP_ACT;
          end
        end
        hrp_pkg::HRP_ACT: begin
          cnt_r <= cnt_r + 1'b1;
          if (beat_done) begin
            dat_r  <= bus16_i ? {16'h0, bus.data[15:0]} : bus.data; // R09
            vld_r  <= 1'b1;
            cnt_r  <= 3'h0;
            left_r <= left_r - 1'b1;
            if (left_r == 5'h1) begin
              lst_r  <= 1'b1;
              cs_n_r <= 1'b1; // R08 R11
              rd_n_r <= 1'b1;
              st_r   <= hrp_pkg::HRP_GAP;
            end else begin
              addr_r <= bus16_i ? addr_r + 1'b1 : addr_r + 7'h2; // R10
            end
          end
        end
        hrp_pkg::HRP_GAP: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == 3'(`HRP_GAP_CYC - 1)) begin
            cnt_r <= 3'h0;
            st_r  <= hrp_pkg::HRP_IDLE; // R08 R11
          end
        end
        default: begin
          st_r   <= hrp_pkg::HRP_IDLE;
          cs_n_r <= 1'b1;
          rd_n_r <= 1'b1;
        end
      endcase
    end
  end
endmodule : hrp_host

/* File: tb/hrp_props.sv */
// Purpose: concurrent checks on the pins between host and device
// Assumes: one clock, sync active-high reset
// Notes:   sees only interface wires and the bus width strap
`timescale 1ns/10ps
module hrp_props (
  input wire logic        clock_i,       // clock
  input wire logic        rst_i,         // sync reset
  input wire logic        chip_select_n, // select, low active
  input wire logic        read_strobe_n, // strobe, low active
  input wire logic [7:1]  addr,          // address
  input wire logic        fifo_sel,      // direct rx fifo
  input wire logic [31:0] data,          // device data
  input wire logic [1:0]  data_oe_n,     // low: device drives lanes
  input wire logic        bus16_i        // 16-bit mode
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic       act;
  logic       act_r;
  logic [7:1] addr_r;
  logic [4:0] beats_r;
  logic [4:0] beats_nxt;
  assign act       = !chip_select_n && !read_strobe_n;
  assign beats_nxt = !act ? 5'h00 : (!act_r ? 5'h01 :
                     (addr != addr_r ? beats_r + 5'h01 : beats_r));
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_i) begin
    act_r   <= rst_i ? 1'b0 : act;
    addr_r  <= addr;
    beats_r <= rst_i ? 5'h00 : beats_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    act && !$past(act);
  endsequence
  sequence s_leave;
    $past(act) && !act;
  endsequence
  sequence s_step;
    act && $past(act) && (addr != $past(addr));
  endsequence
  // no new address and no new select: the device must not reload its data
  sequence s_hold;
    act && $past(act) && $stable(addr) && $stable(fifo_sel);
  endsequence
  AST_OE_ON: assert property (s_start |-> ##[1:2] !data_oe_n[0])
    else $error("lower lanes not driven after access start");
  AST_OE_OFF: assert property (s_leave ##1 !act |-> data_oe_n == 2'b11)
    else $error("lanes still driven after access end");
  AST_UP_32: assert property (s_start ##0 !bus16_i |-> ##[1:2] data_oe_n == 2'b00)
    else $error("upper lanes not driven in 32-bit read");
  AST_UP_16: assert property (bus16_i |-> data_oe_n[1])
    else $error("upper lanes driven in 16-bit mode");
  AST_GAP: assert property (s_leave |-> !act ##1 !act)
    else $error("strobes high too briefly between cycles");
  AST_STEP: assert property (s_step |-> addr == $past(addr) + (bus16_i ? 7'h01 : 7'h02))
    else $error("burst address step wrong");
  AST_SPACE: assert property (s_step |=> act && $stable(addr) && $stable(fifo_sel))
    else $error("burst address held for less than two clocks");
  AST_FSEL: assert property (act && $past(act) |-> $stable(fifo_sel))
    else $error("direct select changed inside an access");
  AST_BEATS: assert property (beats_r <= (bus16_i ? 5'd16 : 5'd8))
    else $error("burst longer than allowed");
  AST_HOLD: assert property (s_hold |=> $stable(data))
    else $error("read data changed without a new access");
endmodule : hrp_props

/* File: tb/host_read_port_sequencing_test.sv */
// Purpose: self-checking bench joining host and device ends
// Assumes: 100 ns clock, inputs driven on the falling edge
// Notes:   the host times read-after-read waits, so the bench never pads
`timescale 1ns/10ps
`include "hrp_defines.svh"
module host_read_port_sequencing_test;
  logic        clock_i;
  logic        rst_i;
  logic        bus16;
  logic [2:0]  vld;       // offers: rx data, rx status, tx status
  wire  [2:0]  rdy;
  logic [31:0] dat;
  logic        drop;
  logic        req_valid;
  logic        req_ready;
  logic [7:1]  req_addr;
  logic        req_fsel;
  logic [4:0]  req_len;
  logic        rsp_valid;
  logic [31:0] rsp_data;
  logic        rsp_last;
  logic [31:0] got[$];
  logic [15:0] half[4];
  logic        ok;
  logic [31:0] frun;
  int          lat;       // one less than the clocks from take to first beat, -1 if none
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;
  hrp_if i_hrp_if ();
  hrp_device #(.RX_DEPTH(4), .DROP_W(16)) i_hrp_device (
    .clock_i(clock_i), .rst_i(rst_i), .bus(i_hrp_if.device), .bus16_i(bus16),
    .rx_valid_i(vld[0]), .rx_ready_o(rdy[0]), .rx_data_i(dat),
    .rxs_valid_i(vld[1]), .rxs_ready_o(rdy[1]), .rxs_data_i(dat),
    .txs_valid_i(vld[2]), .txs_ready_o(rdy[2]), .txs_data_i(dat), .rx_drop_i(drop));
  hrp_host i_hrp_host (
    .clock_i(clock_i), .rst_i(rst_i), .bus(i_hrp_if.host), .bus16_i(bus16),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_addr_i(req_addr),
    .req_fsel_i(req_fsel), .req_len_i(req_len), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data), .rsp_last_o(rsp_last));
  hrp_props i_hrp_props (
    .clock_i(clock_i), .rst_i(rst_i), .chip_select_n(i_hrp_if.chip_select_n),
    .read_strobe_n(i_hrp_if.read_strobe_n), .addr(i_hrp_if.addr),
    .fifo_sel(i_hrp_if.fifo_sel), .data(i_hrp_if.data),
    .data_oe_n(i_hrp_if.data_oe_n), .bus16_i(bus16));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one offer per call; valid drops a cycle later so calls never collide
  task automatic push(input int k, input logic [31:0] d);
    @(negedge clock_i);
    vld[k] = 1'b1;
    dat = d;
    #1 ok = rdy[k];
    @(negedge clock_i);
    vld[k] = 1'b0;
  endtask : push
  task automatic rd(input logic b16, input logic [7:1] a, input logic fs, input logic [4:0] n);
    int t;
    got.delete();
    lat = -1;
    @(negedge clock_i);
    bus16 = b16;
    req_addr = a;
    req_fsel = fs;
    req_len = n;
    req_valid = 1'b1;
    #1;
    for (t = 0; t < 40 && req_ready !== 1'b1; t++) begin
      @(negedge clock_i);
      #1;
    end
    @(negedge clock_i);
    req_valid = 1'b0;
    for (t = 0; t < 100; t++) begin
      @(negedge clock_i);
      if (rsp_valid === 1'b1 && lat < 0) lat = t;
      if (rsp_valid === 1'b1) got.push_back(rsp_data);
      if (rsp_last === 1'b1) break;
    end
  endtask : rd
  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    bus16 = 1'b0;
    vld = 3'h0;
    dat = 32'h0;
    drop = 1'b0;
    req_valid = 1'b0;
    req_addr = 7'h00;
    req_fsel = 1'b0;
    req_len = 5'h00;
    half = '{16'h2222, 16'h1111, 16'h4444, 16'h3333};
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    chk("idle strobes", {30'h0, i_hrp_if.chip_select_n, i_hrp_if.read_strobe_n}, 32'h3);
    chk("idle enables", {30'h0, i_hrp_if.data_oe_n}, 32'h3);
    // test word at 0x30, whole then as two halves
    rd(1'b0, 7'h18, 1'b0, 5'd0);
    chk("single beats", 32'(got.size()), 32'd1);
    chk("test word", got[0], `HRP_TEST_VALUE);
    chk("plain latency", 32'(lat), 32'd1);
    rd(1'b1, 7'h18, 1'b0, 5'd2);
    chk("test low half", got[0], 32'h0000_4321);
    chk("test high half", got[1], 32'h0000_8765);
    // fill the rx buffer until it refuses, then over-long burst drains it
    for (int i = 0; i < 5; i++) begin
      push(0, 32'ha000_0000 + 32'(i));
      chk("rx room", {31'h0, ok}, (i < 4) ? 32'h1 : 32'h0);
    end
    rd(1'b0, 7'h00, 1'b0, 5'd12);
    chk("burst32 beats", 32'(got.size()), 32'd8);
    for (int i = 0; i < 8; i++) begin
      chk("burst32 word", got[i], (i < 4) ? 32'ha000_0000 + 32'(i) : 32'h0);
    end
    // direct select from an address with A[7:3] set, 16-bit burst
    push(0, 32'h1111_2222);
    push(0, 32'h3333_4444);
    rd(1'b1, 7'h60, 1'b1, 5'd20);
    chk("burst16 beats", 32'(got.size()), 32'd16);
    for (int i = 0; i < 16; i++) begin
      chk("direct half", got[i], (i < 4) ? {16'h0, half[i]} : 32'h0);
    end
    push(0, 32'h5a5a_0f0f);
    rd(1'b0, 7'h78, 1'b1, 5'd0);
    chk("direct word", got[0], 32'h5a5a_0f0f);
    // level words read straight after popping reads
    push(0, 32'h0000_00aa);
    push(0, 32'h0000_00bb);
    push(1, 32'hc0de_0001);
    chk("rx status room", {31'h0, ok}, 32'h1);
    rd(1'b0, 7'h10, 1'b0, 5'd0);
    chk("rx status", got[0], 32'hc0de_0001);
    rd(1'b0, 7'h1a, 1'b0, 5'd0);
    chk("rx level", got[0], 32'h0002_0000);
    chk("rx level wait", 32'(lat), 32'(1 + `HRP_FIFO_WAIT_CYC));
    rd(1'b0, 7'h00, 1'b0, 5'd2);
    chk("rx first", got[0], 32'h0000_00aa);
    chk("rx second", got[1], 32'h0000_00bb);
    rd(1'b0, 7'h1a, 1'b0, 5'd0);
    chk("rx level empty", got[0], 32'h0);
    push(2, 32'h7e57_0001);
    chk("tx status room", {31'h0, ok}, 32'h1);
    rd(1'b0, 7'h1c, 1'b0, 5'd0);
    chk("tx level one", got[0], 32'h1);
    chk("tx level no wait", 32'(lat), 32'd1);
    rd(1'b0, 7'h14, 1'b0, 5'd0);
    chk("tx status", got[0], 32'h7e57_0001);
    rd(1'b0, 7'h1c, 1'b0, 5'd0);
    chk("tx level empty", got[0], 32'h0);
    chk("tx level wait", 32'(lat), 32'(1 + `HRP_FIFO_WAIT_CYC));
    // drop counter snapshot, cleared by its own read
    repeat (3) begin
      @(negedge clock_i);
      drop = 1'b1;
      @(negedge clock_i);
      drop = 1'b0;
    end
    rd(1'b0, 7'h1e, 1'b0, 5'd0);
    chk("drop count", got[0], 32'h3);
    rd(1'b0, 7'h1e, 1'b0, 5'd0);
    chk("drop cleared", got[0], 32'h0);
    chk("drop wait", 32'(lat), 32'(1 + `HRP_DROP_WAIT_CYC));
    // two back-to-back free-run reads open four clocks apart
    rd(1'b0, 7'h20, 1'b0, 5'd0);
    frun = got[0];
    rd(1'b0, 7'h20, 1'b0, 5'd0);
    chk("free run step", got[0] - frun, 32'd4);
    final_report();
  end
endmodule : host_read_port_sequencing_test
